// >>> shared/rwt_pkg.sv
// Purpose: Shared constants and types for the runaway watchdog timer.
// Assumes: One clock at the oscillator rate; 8-bit register port.
// Notes:   The counter advances once every two clocks (the phase clock).
package rwt_pkg;

    // Register port geometry.
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [ADDR_W-1:0] OFF_MODE   = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_CODE   = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_CNT0   = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_CNT1   = 3'h4;
    localparam logic [ADDR_W-1:0] OFF_CNT2   = 3'h5;

    // Mode register fields.
    localparam int MODE_EN_BIT   = 7;
    localparam int MODE_PSEL_LSB = 5;
    localparam int MODE_RSTC_BIT = 1;
    localparam int PSEL_W        = 2;

    // Mode register reset values.
    localparam logic              EN_RST   = 1'b1;
    localparam logic [PSEL_W-1:0] PSEL_RST = 2'h0;
    localparam logic              RSTC_RST = 1'b0;

    // Status register fields.
    localparam int STAT_ARMED_BIT = 0;
    localparam int STAT_LOW_BIT   = 1;
    localparam int STAT_HOLD_BIT  = 2;

    // Code register values.
    localparam logic [DATA_W-1:0] CODE_DISABLE = 8'hb1;
    localparam logic [DATA_W-1:0] CODE_CLEAR   = 8'h4e;

    // Counter geometry: taps at 2^16, 2^18, 2^20, 2^22 oscillator periods.
    localparam int CNT_W    = 22;
    localparam int TAP_N    = 4;
    localparam int TAP_LSB  = 14;
    localparam int TAP_STEP = 2;

    // Timing: one state is two clocks; reset hold is the 8-state minimum.
    localparam int CLK_PER_NS    = 8;
    localparam int CLK_PER_STATE = 2;
    localparam int HOLD_STATES   = 8;
    localparam int HOLD_CYCLES   = HOLD_STATES * CLK_PER_STATE;
    localparam int HOLD_W        = 5;
    localparam logic [HOLD_W-1:0] HOLD_LAST = 5'(HOLD_CYCLES - 1);

    typedef enum logic {
        ARM_ON,
        ARM_OFF
    } rwt_arm_t;

    typedef enum logic [1:0] {
        PIN_IDLE,
        PIN_ALARM,
        PIN_RESET
    } rwt_pin_t;

endpackage : rwt_pkg

// >>> rtl/rwt_stage_counter.sv
// Purpose: Free-running binary counter on the phase clock with period taps.
// Assumes: Clear and hold come from logic on the same clock.
// Notes:   Hold zeroes the counter, so standby entry also clears it.
module rwt_stage_counter (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      clear,
    input  wire logic                      hold,
    output logic [rwt_pkg::CNT_W-1:0]      count,
    output logic [rwt_pkg::TAP_N-1:0]      tap_hit
);
    import rwt_pkg::*;

    logic             phase;
    logic             next_phase;
    logic [CNT_W-1:0] next_count;

    always_comb begin
        next_phase = ~phase;
        next_count = count;
        if (hold || clear) begin
            next_phase = 1'b0;
            next_count = '0;
        end else if (phase) begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= 1'b0;
            count <= '0;
        end else begin
            phase <= next_phase;
            count <= next_count;
        end
    end

    // A tap overflows when every stage at and below it carries out.
    for (genvar i = 0; i < TAP_N; i++) begin : g_tap
        localparam int HI = TAP_LSB + TAP_STEP * i;
        assign tap_hit[i] = phase && !hold && !clear && (&count[HI:0]);
    end

endmodule : rwt_stage_counter

// >>> rtl/rwt_runaway_timer.sv
// Purpose: Runaway watchdog timer with alarm pin, NMI and reset connection.
// Assumes: Register port and standby level come from the same clock domain.
// Notes:   Alarm pin and chip reset request are plain active-level outputs.
//
// Local design decisions: strobed register access and the placing of the registers.
module rwt_runaway_timer (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic [rwt_pkg::ADDR_W-1:0]   addr,
    input  wire logic [rwt_pkg::DATA_W-1:0]   wr_data,
    input  wire logic                         wr_en,
    input  wire logic                         rd_en,
    input  wire logic                         standby,
    output logic      [rwt_pkg::DATA_W-1:0]   rd_data,
    output logic                              watchdog_interrupt,
    output logic                              watchdog_out_pin,
    output logic                              chip_reset_out
);
    import rwt_pkg::*;

    // Decoded accesses.
    logic mode_wr;
    logic code_wr;
    logic clear_wr;
    logic disable_wr;

    // Mode register state.
    logic              watchdog_enable_bit;
    logic [PSEL_W-1:0] period_select;
    logic              reset_connect_bit;
    logic              next_watchdog_enable_bit;
    logic [PSEL_W-1:0] next_period_select;
    logic              next_reset_connect_bit;

    // Arming state.
    rwt_arm_t arm;
    rwt_arm_t next_arm;

    // Alarm pin state.
    rwt_pin_t          pin;
    rwt_pin_t          next_pin;
    logic [HOLD_W-1:0] hold_cnt;
    logic [HOLD_W-1:0] next_hold_cnt;
    logic              self_rst;
    logic              next_self_rst;
    logic              next_watchdog_interrupt;
    logic              next_watchdog_out_pin;
    logic              next_chip_reset_out;

    // Read port state.
    logic [DATA_W-1:0] next_rd_data;

    // Counter.
    logic [CNT_W-1:0]  count;
    logic [TAP_N-1:0]  tap_hit;
    logic              overflow;
    logic              cnt_clear;

    assign mode_wr    = wr_en && (addr == OFF_MODE);
    assign code_wr    = wr_en && (addr == OFF_CODE);
    // Any other code value matches neither compare and so does nothing.
    assign clear_wr   = code_wr && (wr_data == CODE_CLEAR);
    assign disable_wr = code_wr && (wr_data == CODE_DISABLE);

    // The self reset clears the counter as well as the control state.
    assign cnt_clear = clear_wr || self_rst;

    // Standby holds the counter at zero; bus grant has no effect at all,
    // because the timer keeps running whoever owns the external bus.
    // The counter's own asynchronous reset lets it run from the first
    // edge after release.
    rwt_stage_counter u_counter (
        .clk     (clk),
        .rst     (rst),
        .clear   (cnt_clear),
        .hold    (standby),
        .count   (count),
        .tap_hit (tap_hit)
    );

    // Only the selected tap matters; the counter itself wraps on its own.
    assign overflow = tap_hit[period_select];

    // Mode register.
    always_comb begin
        next_watchdog_enable_bit = watchdog_enable_bit;
        next_period_select       = period_select;
        next_reset_connect_bit   = reset_connect_bit;
        if (self_rst) begin
            next_watchdog_enable_bit = EN_RST;
            next_period_select       = PSEL_RST;
            next_reset_connect_bit   = RSTC_RST;
        end else if (mode_wr) begin
            next_watchdog_enable_bit = wr_data[MODE_EN_BIT];
            next_period_select =
                wr_data[MODE_PSEL_LSB +: PSEL_W];
            next_reset_connect_bit   = wr_data[MODE_RSTC_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            watchdog_enable_bit <= EN_RST;
            period_select       <= PSEL_RST;
            reset_connect_bit   <= RSTC_RST;
        end else begin
            watchdog_enable_bit <= next_watchdog_enable_bit;
            period_select       <= next_period_select;
            reset_connect_bit   <= next_reset_connect_bit;
        end
    end

    // Arming. The two-step disable makes it hard for a runaway program to
    // switch the watchdog off by a single stray write.
    always_comb begin
        next_arm = arm;
        if (self_rst) begin
            next_arm = ARM_ON;
        end else if (watchdog_enable_bit) begin
            next_arm = ARM_ON;
        end else if (disable_wr) begin
            next_arm = ARM_OFF;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arm <= ARM_ON;
        end else begin
            arm <= next_arm;
        end
    end

    // Alarm pin, interrupt and reset hold.
    always_comb begin
        next_pin                = pin;
        next_hold_cnt           = hold_cnt;
        next_self_rst           = 1'b0;
        next_watchdog_interrupt = 1'b0;
        case (pin)
            PIN_IDLE: begin
                // Disabled only masks the outputs; the count goes on.
                if (overflow && arm == ARM_ON) begin
                    next_watchdog_interrupt = 1'b1;
                    next_hold_cnt           = '0;
                    if (reset_connect_bit) begin
                        next_pin = PIN_RESET;
                    end else begin
                        next_pin = PIN_ALARM;
                    end
                end
            end
            PIN_ALARM: begin
                // Further overflows still interrupt, as an interval timer.
                if (overflow && arm == ARM_ON) begin
                    next_watchdog_interrupt = 1'b1;
                end
                if (arm == ARM_OFF && clear_wr) begin
                    next_pin = PIN_IDLE;
                end
            end
            PIN_RESET: begin
                if (hold_cnt == HOLD_LAST) begin
                    next_pin      = PIN_IDLE;
                    next_self_rst = 1'b1;
                end else begin
                    next_hold_cnt = hold_cnt + 1'b1;
                end
            end
            default: begin
                next_pin = PIN_IDLE;
            end
        endcase
        next_watchdog_out_pin = (next_pin == PIN_IDLE);
        next_chip_reset_out   = (next_pin == PIN_RESET);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin                <= PIN_IDLE;
            hold_cnt           <= '0;
            self_rst           <= 1'b0;
            watchdog_interrupt <= 1'b0;
            watchdog_out_pin   <= 1'b1;
            chip_reset_out     <= 1'b0;
        end else begin
            pin                <= next_pin;
            hold_cnt           <= next_hold_cnt;
            self_rst           <= next_self_rst;
            watchdog_interrupt <= next_watchdog_interrupt;
            watchdog_out_pin   <= next_watchdog_out_pin;
            chip_reset_out     <= next_chip_reset_out;
        end
    end

    // Read port. The code register is write only and reads as zero, as do
    // unmapped offsets and unused bits.
    always_comb begin
        next_rd_data = '0;
        if (rd_en) begin
            case (addr)
                OFF_MODE: begin
                    next_rd_data[MODE_EN_BIT] = watchdog_enable_bit;
                    next_rd_data[MODE_PSEL_LSB +: PSEL_W] = period_select;
                    next_rd_data[MODE_RSTC_BIT] = reset_connect_bit;
                end
                OFF_STATUS: begin
                    next_rd_data[STAT_ARMED_BIT] = (arm == ARM_ON);
                    next_rd_data[STAT_LOW_BIT]   = (pin != PIN_IDLE);
                    next_rd_data[STAT_HOLD_BIT]  = (pin == PIN_RESET);
                end
                OFF_CNT0: begin
                    next_rd_data = count[7:0];
                end
                OFF_CNT1: begin
                    next_rd_data = count[15:8];
                end
                OFF_CNT2: begin
                    next_rd_data = {2'h0, count[CNT_W-1:16]};
                end
                default: begin
                    next_rd_data = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= next_rd_data;
        end
    end

endmodule : rwt_runaway_timer

// >>> tb/rwt_monitor.sv
// Purpose: Port-level checks for the runaway watchdog timer.
// Assumes: One clock domain; rst is asynchronous and active high.
// Notes:   Counter state is seen only through register reads.
module rwt_monitor
    import rwt_pkg::*;
(
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic [rwt_pkg::ADDR_W-1:0] addr,
    input wire logic [rwt_pkg::DATA_W-1:0] wr_data,
    input wire logic                       wr_en,
    input wire logic                       rd_en,
    input wire logic                       standby,
    input wire logic [rwt_pkg::DATA_W-1:0] rd_data,
    input wire logic                       watchdog_interrupt,
    input wire logic                       watchdog_out_pin,
    input wire logic                       chip_reset_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    wire logic clear_wr;
    assign clear_wr = wr_en && addr == OFF_CODE && wr_data == CODE_CLEAR;

    // Eight cycles of the reset request, pin held low meanwhile.
    sequence s_hold8;
        (chip_reset_out && !watchdog_out_pin) [*8];
    endsequence

    int_pulse_a: assert property (
        watchdog_interrupt |=> !watchdog_interrupt)
        else $error("interrupt wider than one cycle");
    int_pin_a: assert property (
        watchdog_interrupt |-> !watchdog_out_pin)
        else $error("interrupt without pin low");
    pin_fall_a: assert property (
        $fell(watchdog_out_pin) |-> watchdog_interrupt)
        else $error("pin fell without overflow");
    pin_rise_a: assert property (
        $rose(watchdog_out_pin) |-> $past(clear_wr)
        || $past(chip_reset_out) || $past(chip_reset_out, 2))
        else $error("pin released without clear");
    reset_hold_a: assert property ($rose(chip_reset_out)
        |-> s_hold8 ##1 s_hold8 ##1 !chip_reset_out)
        else $error("reset request not sixteen cycles");
    rd_idle_a: assert property (!rd_en |=> rd_data == '0)
        else $error("read data outside read cycle");
    code_read_a: assert property (
        rd_en && (addr == OFF_CODE || addr > OFF_CNT2)
        |=> rd_data == '0)
        else $error("write-only or unmapped read nonzero");
    standby_cnt_a: assert property (
        rd_en && addr == OFF_CNT0 && standby
        && $past(standby) |=> rd_data == '0)
        else $error("counter moved in standby");
    standby_int_a: assert property (standby && $past(standby)
        |-> !watchdog_interrupt)
        else $error("interrupt in standby");
endmodule : rwt_monitor

// >>> tb/rwt_runaway_timer_tb_top.sv
// Purpose: Self-checking bench for the runaway watchdog timer.
// Assumes: 125 MHz clock; register reads answer one cycle later.
// Notes:   Two full overflows at the shortest period set the run time.
module rwt_runaway_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rwt_pkg::*;

    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wr_data = '0;
    logic              wr_en = 1'b0;
    logic              rd_en = 1'b0;
    logic              standby = 1'b0;
    logic [DATA_W-1:0] rd_data;
    logic              watchdog_interrupt;
    logic              watchdog_out_pin;
    logic              chip_reset_out;
    int                bad_count = 0;
    int                comparisons = 0;
    int                cyc = 0;

    always #4 clk = ~clk;

    rwt_runaway_timer i_rwt_runaway_timer (
        .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .standby(standby),
        .rd_data(rd_data), .watchdog_interrupt(watchdog_interrupt),
        .watchdog_out_pin(watchdog_out_pin), .chip_reset_out(chip_reset_out)
    );

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // The ceiling leaves margin over two shortest-period overflows.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 150000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
        comparisons++;
        if (got >= lo && got <= hi) begin
        end else begin
            bad_count++;
            $display("Error at %0t: got %h expected %h..%h",
                     $time, got, lo, hi);
        end
    endtask : chk_rng

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd

    task automatic wait_int(output logic [31:0] n);
        n = 0;
        while (watchdog_interrupt !== 1'b1 && n < 70000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_int

    task automatic t_regs();
        logic [DATA_W-1:0] d;
        repeat (200) @(posedge clk);
        rd(OFF_CNT0, d);
        chk_rng(d, 96, 106);
        rd(OFF_MODE, d);
        chk(d, 8'h80);
        rd(OFF_CODE, d);
        chk(d, 8'h00);
        wr(3'h7, 8'h55);
        rd(3'h7, d);
        chk(d, 8'h00);
        wr(OFF_MODE, 8'hff);
        rd(OFF_MODE, d);
        chk(d, 8'he2);
        wr(OFF_MODE, 8'h80);
        $display("regs done");
    endtask : t_regs

    task automatic t_count();
        logic [DATA_W-1:0] d;
        wr(OFF_CODE, CODE_CLEAR);
        rd(OFF_CNT1, d);
        chk(d, 8'h00);
        rd(OFF_CNT0, d);
        chk_rng(d, 0, 4);
        repeat (1000) @(posedge clk);
        wr(OFF_CODE, 8'h55);
        rd(OFF_CNT1, d);
        chk(d, 8'h01);
        @(posedge clk);
        standby <= 1'b1;
        repeat (20) @(posedge clk);
        rd(OFF_CNT0, d);
        chk(d, 8'h00);
        rd(OFF_CNT1, d);
        chk(d, 8'h00);
        @(posedge clk);
        standby <= 1'b0;
        repeat (100) @(posedge clk);
        rd(OFF_CNT0, d);
        chk_rng(d, 48, 56);
        $display("count done");
    endtask : t_count

    task automatic t_alarm();
        logic [DATA_W-1:0] d;
        logic [31:0]       n;
        wr(OFF_CODE, CODE_DISABLE);
        wr(OFF_CODE, CODE_CLEAR);
        wait_int(n);
        chk_rng(n, 65530, 65540);
        chk(watchdog_out_pin, 1'b0);
        rd(OFF_STATUS, d);
        chk(d, 8'h03);
        wr(OFF_CODE, CODE_CLEAR);
        @(posedge clk);
        #1;
        chk(watchdog_out_pin, 1'b0);
        wr(OFF_MODE, 8'h00);
        wr(OFF_CODE, CODE_DISABLE);
        repeat (100) @(posedge clk);
        rd(OFF_CNT0, d);
        chk_rng(d, 48, 60);
        wr(OFF_CODE, CODE_CLEAR);
        @(posedge clk);
        #1;
        chk(watchdog_out_pin, 1'b1);
        $display("alarm done");
    endtask : t_alarm

    // Counting high samples over a window tolerates a late rising edge.
    task automatic t_link();
        logic [DATA_W-1:0] d;
        logic [31:0]       n;
        wr(OFF_CODE, CODE_CLEAR);
        wr(OFF_MODE, 8'h82);
        wait_int(n);
        chk_rng(n, 65530, 65540);
        n = 0;
        for (int i = 0; i < 40; i++) begin
            n = n + chip_reset_out;
            @(posedge clk);
            #1;
        end
        chk(n, 16);
        chk(watchdog_out_pin, 1'b1);
        rd(OFF_MODE, d);
        chk(d, 8'h80);
        $display("link done");
    endtask : t_link

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_count();
        t_alarm();
        t_link();
        tally_and_finish();
    end
endmodule : rwt_runaway_timer_tb_top

bind rwt_runaway_timer rwt_monitor i_rwt_monitor (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .standby(standby), .rd_data(rd_data),
    .watchdog_interrupt(watchdog_interrupt),
    .watchdog_out_pin(watchdog_out_pin), .chip_reset_out(chip_reset_out)
);
